/* File: rtl/iopx_pkg.sv */
// Constants shared by the port and expansion-bus block and its edge helper.
// Assumes a 100 MHz system clock and an AXI4-Lite register bus with 8-bit byte addresses.
package iopx_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int NPORT = 5;
  localparam int PIDX_A = 0;
  localparam int PIDX_B = 1;
  localparam int PIDX_C = 2;
  localparam int PIDX_D = 3;
  localparam int PIDX_F = 4;
  localparam int ADDR_W = 8;
  localparam int SYNC_W = 48;

  // ****************************************************************
  // Positions inside the synchronised input vector
  // ****************************************************************
  localparam int SY_NMI = 40;
  localparam int SY_RISING_IRQ_IN = 41;
  localparam int SY_AN_LO = 42;
  localparam int SY_MODE_LO = 46;
  localparam int SY_C_BASE = 16;
  localparam int SY_D_BASE = 24;
  localparam int C_RX = 1;
  localparam int C_SCK = 2;
  localparam int C_TI = 3;
  localparam int C_CI = 5;

  // ****************************************************************
  // Register map, byte addresses
  // ****************************************************************
  localparam logic [7:0] PORT_STRIDE = 8'h10;
  localparam logic [7:0] OFS_DIR = 8'h00;
  localparam logic [7:0] OFS_OUT = 8'h04;
  localparam logic [7:0] OFS_IN = 8'h08;
  localparam logic [7:0] OFS_CMODE = 8'h0c;
  localparam logic [7:0] ADDR_EXP_CTRL = 8'h50;
  localparam logic [7:0] ADDR_STATUS = 8'h54;
  localparam logic [7:0] ADDR_EDGE = 8'h58;

  // ****************************************************************
  // Reset values and encodings
  // ****************************************************************
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] OUT_RESET = 8'h00;
  localparam logic [7:0] CMODE_RESET = 8'h00;
  localparam logic [2:0] EXP_NONE = 3'h0;
  localparam logic [2:0] EXP_256 = 3'h1;
  localparam logic [2:0] EXP_4K = 3'h2;
  localparam logic [2:0] EXP_16K = 3'h3;
  localparam logic [2:0] EXP_60K = 3'h4;
  localparam logic [15:0] ROM_TOP = 16'h0fff;
  localparam logic [15:0] RAM_BASE = 16'hff00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int STROBE_NS = 40;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {SQ_IDLE, SQ_ADDR, SQ_STROBE, SQ_DONE} iopx_seq_e;

endpackage

/* File: rtl/iopx_edge_if.sv */
// Carrier between the main block and its synchroniser and edge detector.
// Assumes both ends run on sys_clk.
`timescale 1ns/10ps
interface iopx_edge_if import iopx_pkg::*; ();
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] level;
  logic [SYNC_W-1:0] rise;
  logic [SYNC_W-1:0] fall;
  modport src (input raw, output level, rise, fall);
  modport dst (output raw, input level, rise, fall);
endinterface

/* File: rtl/iopx_sync_edge.sv */
// Two-stage synchroniser and edge detector for every pin input of the block.
// Assumes raw pins are asynchronous to sys_clk; rst is synchronous, active high.
`timescale 1ns/10ps
module iopx_sync_edge import iopx_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  iopx_edge_if.src e
);

  // ****************************************************************
  // Per-bit synchroniser
  // ****************************************************************
  // The chain runs through reset so the straps are seen; edges wait until reset ends.
  genvar i;
  generate
    for (i = 0; i < SYNC_W; i++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      always_ff @(posedge sys_clk) begin
        s1 <= e.raw[i];
        s2 <= s1;
        s3 <= s2;
      end
      assign e.level[i] = s2;
      assign e.rise[i] = s2 & ~s3 & ~rst;
      assign e.fall[i] = ~s2 & s3 & ~rst;
    end
  endgenerate

endmodule // iopx_sync_edge

/* File: rtl/iopx_ports.sv */
// Five pin ports, port C alternate functions, edge inputs and the expansion bus sequencer.
// Assumes an AXI4-Lite master on sys_clk and a core that holds core_req until core_ack.
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
// What this block does
// - Ports A, B and F are eight three-state lines, each direction set per bit.
// - Reset turns every line of ports A and B into an input.
// - Reset leaves port C in plain mode, all inputs, no alternate function.
// - Each port C line can be switched to serial, timer or counter duty.
// - C0 tx, C1 rx, C2 serial clock, C3 timer/irq2, C4 timer out, C5-7 counter.
// - Serial clock pin is driven only when the internal clock is chosen.
// - Port D has one direction for all eight lines.
// - With expansion on, port D carries multiplexed low address and data.
// - With 4K, 16K or 60K expansion, port F drives high address bits 8-11, 8-13 or 8-15.
// - General lines keep output values latched; input lines are not driven.
// - The upper four analog lines flag falling edges as digital inputs.
// - A falling edge on the nonmaskable input raises its request.
// - A rising edge on interrupt input one raises a request.
// - A falling edge on port C line 3 raises interrupt two.
// - Mode pins then output opcode fetch and I/O-versus-memory flags.
// - Read strobe pulls low for external reads and stays high in reset.
// - Write strobe pulls low with valid write data and stays high in reset.
// - Address latch enable pulses while the low address byte sits on port D.
// - 0-4095 is on-chip ROM, 65280-65535 on-chip RAM, the rest external.
// - Besides single-chip use there are four expansion modes; none keeps D as I/O.
// - 256 B keeps F as I/O; 4K uses F0-3, 16K F0-5, 60K all of F.
module iopx_ports import iopx_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] gp_port_first_in,
  output logic [7:0] gp_port_first_out,
  output logic [7:0] gp_port_first_oe,
  input wire logic [7:0] gp_port_second_in,
  output logic [7:0] gp_port_second_out,
  output logic [7:0] gp_port_second_oe,
  input wire logic [7:0] ctrl_port_third_in,
  output logic [7:0] ctrl_port_third_out,
  output logic [7:0] ctrl_port_third_oe,
  input wire logic [7:0] mux_port_fourth_in,
  output logic [7:0] mux_port_fourth_out,
  output logic [7:0] mux_port_fourth_oe,
  input wire logic [7:0] high_addr_port_fifth_in,
  output logic [7:0] high_addr_port_fifth_out,
  output logic [7:0] high_addr_port_fifth_oe,
  input wire logic nmi_n_in,
  input wire logic rising_irq_in,
  input wire logic [3:0] upper_analog_edge_inputs,
  input wire logic mode_sel_hi_in,
  output logic mode_sel_hi_out,
  output logic mode_sel_hi_oe,
  input wire logic mode_sel_lo_in,
  output logic mode_sel_lo_out,
  output logic mode_sel_lo_oe,
  output logic rd_n,
  output logic wr_n,
  output logic ale,
  input wire logic serial_tx,
  output logic serial_rx,
  input wire logic serial_clk_out,
  output logic serial_clk_in,
  input wire logic timer_output_line,
  output logic timer_input_line,
  output logic counter_input_line,
  input wire logic counter_output_zero,
  input wire logic counter_output_one,
  output logic nmi_req,
  output logic irq1_req,
  output logic irq2_req,
  input wire logic core_req,
  input wire logic [15:0] core_addr,
  input wire logic core_we,
  input wire logic core_io,
  input wire logic core_fetch,
  input wire logic [7:0] core_wdata,
  output logic core_ack,
  output logic core_local,
  output logic [7:0] core_rdata
);

  // ****************************************************************
  // Synchronised pins
  // ****************************************************************
  iopx_edge_if eif ();

  assign eif.raw = {mode_sel_hi_in, mode_sel_lo_in, upper_analog_edge_inputs, rising_irq_in,
                    nmi_n_in, high_addr_port_fifth_in, mux_port_fourth_in, ctrl_port_third_in,
                    gp_port_second_in, gp_port_first_in};

  iopx_sync_edge u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .e(eif.src)
  );

  // ****************************************************************
  // Decoding
  // ****************************************************************
  // Returns {valid, kind, port}; kind 0 dir, 1 out, 2 in, 3 mode, 4 ctrl, 5 status, 6 edge.
  function automatic logic [6:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [7:0] ofs;
    logic [2:0] p;
    ofs = a & (PORT_STRIDE - 8'h01);
    p = 3'(a / PORT_STRIDE);
    reg_sel = 7'h00;
    if (a == ADDR_EXP_CTRL) reg_sel = {1'b1, 3'h4, 3'h0};
    else if (a == ADDR_STATUS) reg_sel = {1'b1, 3'h5, 3'h0};
    else if (a == ADDR_EDGE) reg_sel = {1'b1, 3'h6, 3'h0};
    else if (a < 8'(NPORT) * PORT_STRIDE) begin
      if (ofs == OFS_DIR) reg_sel = {1'b1, 3'h0, p};
      else if (ofs == OFS_OUT) reg_sel = {1'b1, 3'h1, p};
      else if (ofs == OFS_IN) reg_sel = {1'b1, 3'h2, p};
      else if (ofs == OFS_CMODE && p == 3'(PIDX_C)) reg_sel = {1'b1, 3'h3, p};
    end
  endfunction

  function automatic logic [7:0] addr_mask(input logic [2:0] sz);
    unique case (sz)
      EXP_4K: addr_mask = 8'h0f;
      EXP_16K: addr_mask = 8'h3f;
      EXP_60K: addr_mask = 8'hff;
      default: addr_mask = 8'h00;
    endcase
  endfunction

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [7:0] dir_q [NPORT];
  logic [7:0] out_q [NPORT];
  logic [7:0] cmode_q;
  logic [2:0] exp_size;
  logic sck_internal;
  logic [6:0] edge_q;
  logic [1:0] strap;
  logic run;
  logic aw_got;
  logic w_got;
  logic [ADDR_W-1:0] aw_addr;
  logic [7:0] w_byte;
  logic w_en;
  logic do_write;
  logic [6:0] wsel;
  logic [6:0] rsel;
  logic [7:0] next_rbyte;
  logic exp_on;
  logic [7:0] f_mask;
  logic [6:0] edge_set;
  iopx_seq_e seq;
  logic [2:0] cnt;
  logic [15:0] bus_addr;
  logic [7:0] bus_wdata;
  logic bus_we;
  logic bus_io;
  logic bus_fetch;

  assign exp_on = (strap != 2'h0) && (exp_size != EXP_NONE);
  assign f_mask = exp_on ? addr_mask(exp_size) : 8'h00;

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
  assign s_axi_wready = ~w_got & ~s_axi_bvalid;
  assign do_write = aw_got & w_got & ~s_axi_bvalid;
  assign wsel = reg_sel(aw_addr);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_byte <= 8'h00;
      w_en <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_en <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wsel[6] ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Port and control registers
  // ****************************************************************
  // Only byte lane 0 carries register data; other lanes are ignored.
  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_port
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          dir_q[gp] <= DIR_RESET;
          out_q[gp] <= OUT_RESET;
        end else if (do_write && w_en && wsel[6] && wsel[2:0] == 3'(gp)) begin
          if (wsel[5:3] == 3'h0) begin
            if (gp == PIDX_D) dir_q[gp] <= {8{w_byte[0]}};
            else dir_q[gp] <= w_byte;
          end
          if (wsel[5:3] == 3'h1) out_q[gp] <= w_byte;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmode_q <= CMODE_RESET;
      exp_size <= EXP_NONE;
      sck_internal <= 1'b0;
    end else if (do_write && w_en && wsel[6]) begin
      if (wsel[5:3] == 3'h3) cmode_q <= w_byte;
      if (wsel[5:3] == 3'h4) begin
        exp_size <= (w_byte[2:0] > EXP_60K) ? EXP_NONE : w_byte[2:0];
        sck_internal <= w_byte[3];
      end
    end
  end

  // ****************************************************************
  // Edge flags
  // ****************************************************************
  // A flag raised in the same cycle as its clear stays set.
  assign edge_set = {eif.fall[SY_AN_LO + 3:SY_AN_LO],
                     eif.fall[SY_C_BASE + C_TI] & cmode_q[C_TI],
                     eif.rise[SY_RISING_IRQ_IN],
                     eif.fall[SY_NMI]};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      edge_q <= 7'h00;
    end else if (do_write && w_en && wsel[6] && wsel[5:3] == 3'h6) begin
      edge_q <= (edge_q & ~w_byte[6:0]) | edge_set;
    end else begin
      edge_q <= edge_q | edge_set;
    end
  end

  assign nmi_req = edge_set[0];
  assign irq1_req = edge_set[1];
  assign irq2_req = edge_set[2];

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  assign s_axi_arready = ~s_axi_rvalid;
  assign rsel = reg_sel(s_axi_araddr);

  always_comb begin
    next_rbyte = 8'h00;
    unique case (rsel[5:3])
      3'h0: next_rbyte = dir_q[rsel[2:0]];
      3'h1: next_rbyte = out_q[rsel[2:0]];
      3'h2: next_rbyte = eif.level[rsel[2:0] * 8 +: 8];
      3'h3: next_rbyte = cmode_q;
      3'h4: next_rbyte = {4'h0, sck_internal, exp_size};
      3'h5: next_rbyte = {4'h0, seq != SQ_IDLE, exp_on, strap};
      3'h6: next_rbyte = {1'b0, edge_q};
      default: next_rbyte = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rsel[6] ? next_rbyte : 8'h00};
      s_axi_rresp <= rsel[6] ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Mode straps
  // ****************************************************************
  // The straps are caught on every reset edge, so the last value before release counts.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      strap <= eif.level[SY_MODE_LO +: 2];
      run <= 1'b0;
    end else begin
      run <= 1'b1;
    end
  end

  assign mode_sel_hi_oe = run;
  assign mode_sel_lo_oe = run;

  // ****************************************************************
  // Expansion bus sequencer
  // ****************************************************************
  // The strobe lasts several cycles so read data passes the pin synchroniser first.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seq <= SQ_IDLE;
      cnt <= 3'h0;
      bus_addr <= 16'h0000;
      bus_wdata <= 8'h00;
      bus_we <= 1'b0;
      bus_io <= 1'b0;
      bus_fetch <= 1'b0;
      ale <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      core_ack <= 1'b0;
      core_local <= 1'b0;
      core_rdata <= 8'h00;
    end else begin
      core_ack <= 1'b0;
      unique case (seq)
        SQ_IDLE: begin
          // The edge that shows the acknowledge still sees the old request; it starts nothing.
          if (core_req && !core_ack) begin
            bus_addr <= core_addr;
            bus_wdata <= core_wdata;
            bus_we <= core_we;
            bus_io <= core_io;
            bus_fetch <= core_fetch;
            if (!exp_on || (!core_io && (core_addr <= ROM_TOP || core_addr >= RAM_BASE))) begin
              core_local <= 1'b1;
              seq <= SQ_DONE;
            end else begin
              core_local <= 1'b0;
              ale <= 1'b1;
              seq <= SQ_ADDR;
            end
          end
        end
        SQ_ADDR: begin
          ale <= 1'b0;
          cnt <= 3'(STROBE_CYC - 1);
          rd_n <= bus_we;
          wr_n <= ~bus_we;
          seq <= SQ_STROBE;
        end
        SQ_STROBE: begin
          if (cnt == 3'h0) begin
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            if (!bus_we) core_rdata <= eif.level[SY_D_BASE +: 8];
            seq <= SQ_DONE;
          end else begin
            cnt <= cnt - 3'h1;
          end
        end
        SQ_DONE: begin
          core_ack <= 1'b1;
          seq <= SQ_IDLE;
        end
        default: seq <= SQ_IDLE;
      endcase
    end
  end

  assign mode_sel_hi_out = bus_fetch & (seq != SQ_IDLE);
  assign mode_sel_lo_out = bus_io & (seq != SQ_IDLE);

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  assign gp_port_first_out = out_q[PIDX_A];
  assign gp_port_first_oe = dir_q[PIDX_A];
  assign gp_port_second_out = out_q[PIDX_B];
  assign gp_port_second_oe = dir_q[PIDX_B];

  // Alternate outputs take the line over; alternate inputs leave it undriven.
  assign ctrl_port_third_out = (out_q[PIDX_C] & ~cmode_q) | (cmode_q & {counter_output_one,
                               counter_output_zero, 1'b0, timer_output_line, 1'b0,
                               serial_clk_out, 1'b0, serial_tx});
  assign ctrl_port_third_oe = (dir_q[PIDX_C] & ~cmode_q) | (cmode_q & {3'b110, 1'b1, 1'b0,
                              sck_internal, 2'b01});
  assign serial_rx = eif.level[SY_C_BASE + C_RX];
  assign serial_clk_in = eif.level[SY_C_BASE + C_SCK];
  assign timer_input_line = eif.level[SY_C_BASE + C_TI];
  assign counter_input_line = eif.level[SY_C_BASE + C_CI];

  // During a cycle the low byte goes out with the latch pulse, then write data.
  assign mux_port_fourth_out = !exp_on ? out_q[PIDX_D] :
                               (seq == SQ_ADDR || ale) ? bus_addr[7:0] : bus_wdata;
  assign mux_port_fourth_oe = !exp_on ? dir_q[PIDX_D] :
                              {8{ale | (seq == SQ_ADDR) | ~wr_n}};

  assign high_addr_port_fifth_out = (bus_addr[15:8] & f_mask) | (out_q[PIDX_F] & ~f_mask);
  assign high_addr_port_fifth_oe = f_mask | dir_q[PIDX_F];

endmodule // iopx_ports

/* File: verif/iopx_ports_assertions.sv */
// Concurrent checks on the strobes, port directions and edge requests.
// Assumes a bind to iopx_ports, one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module iopx_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ale,
  input wire logic [7:0] gp_port_first_oe,
  input wire logic [7:0] gp_port_second_oe,
  input wire logic [7:0] mux_port_fourth_oe,
  input wire logic nmi_n_in,
  input wire logic nmi_req,
  input wire logic rising_irq_in,
  input wire logic irq1_req
);
  // ********
  // Checks
  // ********
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // The reset checks drop the default disable, since they watch reset itself.
  rst_strobe_a: assert property (disable iff (1'b0)
    rst |=> rd_n && wr_n && !ale) else $error("strobe active in reset");
  rst_dir_a: assert property (disable iff (1'b0)
    rst |=> !gp_port_first_oe && !gp_port_second_oe) else $error("port driven in reset");
  ale_pulse_a: assert property ($rose(ale) |=> !ale)
    else $error("ale longer than one cycle");
  ale_strobe_a: assert property ($rose(ale) |=> $fell(rd_n) || $fell(wr_n))
    else $error("no strobe after ale");
  wr_len_a: assert property ($fell(wr_n) |-> !wr_n [*4] ##1 wr_n)
    else $error("write strobe length");
  rd_len_a: assert property ($fell(rd_n) |-> !rd_n [*4] ##1 rd_n)
    else $error("read strobe length");
  d_dir_a: assert property (mux_port_fourth_oe == 8'h00 || mux_port_fourth_oe == 8'hff)
    else $error("port d direction split");
  nmi_edge_a: assert property ($fell(nmi_n_in) |-> ##[2:4] nmi_req)
    else $error("nmi request missing");
  rising_irq_in_edge_a: assert property ($rose(rising_irq_in) |-> ##[2:4] irq1_req)
    else $error("irq1 request missing");
  cover property ($fell(wr_n));
  cover property ($fell(rd_n));
  cover property (nmi_req);
endmodule // iopx_chk

/* File: verif/iopx_ext_mem.sv */
// Behavioural external memory on the multiplexed low address and data bus.
// Assumes the strobes and the address latch enable come from the block on sys_clk.
`timescale 1ns/10ps
module iopx_ext_mem (
  input wire logic sys_clk,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] ad_out,
  output logic [7:0] ad_in
);
  logic [7:0] mem [256];
  logic [7:0] lo_q = 8'h00;
  // Only the low byte is decoded, which keeps the array small.
  always_ff @(posedge sys_clk) begin
    if (ale) lo_q <= ad_out;
    if (!wr_n) mem[lo_q] <= ad_out;
  end
  // A released bus shows the inverted latched address, never stale data.
  assign ad_in = rd_n ? ~lo_q : mem[lo_q];
endmodule // iopx_ext_mem

/* File: verif/io_ports_and_memory_expansion_tb.sv */
// Self-checking bench for the port and expansion-bus block.
// Assumes the package, the block, its checker and the external memory model.
`timescale 1ns/10ps
module io_ports_and_memory_expansion_tb import iopx_pkg::*; ();
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, hit = 1'b0, a_m1, a_io, a_loc;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, a_d, a_f, a_foe;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] gp_port_first_in = 8'h5a, gp_port_second_in = 8'hc3, ctrl_port_third_in = 8'hff;
  logic [7:0] high_addr_port_fifth_in = 8'h96, gp_port_first_out, gp_port_first_oe;
  logic [7:0] gp_port_second_out, gp_port_second_oe, ctrl_port_third_out, ctrl_port_third_oe;
  logic [7:0] mux_port_fourth_in, mux_port_fourth_out, mux_port_fourth_oe, core_rdata;
  logic [7:0] high_addr_port_fifth_out, high_addr_port_fifth_oe;
  logic nmi_n_in = 1'b1, rising_irq_in = 1'b0, serial_tx = 1'b1, serial_clk_out = 1'b0;
  logic timer_output_line = 1'b0, counter_output_zero = 1'b0, counter_output_one = 1'b1;
  logic [3:0] upper_analog_edge_inputs = 4'hf;
  logic mode_sel_hi_out, mode_sel_hi_oe, mode_sel_lo_out, mode_sel_lo_oe, rd_n, wr_n, ale;
  logic serial_rx, serial_clk_in, timer_input_line, counter_input_line;
  logic nmi_req, irq1_req, irq2_req, core_ack, core_local;
  logic core_req = 1'b0, core_we = 1'b0, core_io = 1'b0, core_fetch = 1'b0;
  logic [15:0] core_addr = 16'h0;
  logic [7:0] core_wdata = 8'h00;
  logic [7:0] fmask [5] = '{8'h00, 8'h00, 8'h0f, 8'h3f, 8'hff};
  logic [15:0] lad [4] = '{16'h0fff, 16'h1000, 16'hfeff, 16'hff00};
  int err_count = 0, cmp_count = 0;
  // The strap pins read the strap level until the block takes them over.
  wire logic mode_sel_hi_in = mode_sel_hi_oe ? mode_sel_hi_out : 1'b1;
  wire logic mode_sel_lo_in = mode_sel_lo_oe ? mode_sel_lo_out : 1'b0;

  always #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
  iopx_ports dut_u (.*);
  iopx_ext_mem mem_u (.sys_clk(sys_clk), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
    .ad_out(mux_port_fourth_out), .ad_in(mux_port_fourth_in));

  // ********
  // Tasks
  // ********
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, er);
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    chk("rresp", s_axi_rresp, er);
    chk("rdata", s_axi_rdata, {24'h0, d});
  endtask
  task automatic cyc(input logic [15:0] a, input logic we, input logic io, input logic [7:0] d);
    int n = 0;
    @(posedge sys_clk);
    {core_addr, core_we, core_io, core_wdata} <= {a, we, io, d};
    core_fetch <= !we && !io;
    core_req <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (ale) begin
        {a_d, a_f, a_foe} = {mux_port_fourth_out, high_addr_port_fifth_out, high_addr_port_fifth_oe};
        {a_m1, a_io} = {mode_sel_hi_out, mode_sel_lo_out};
      end
    end while (!core_ack && n < 50);
    core_req <= 1'b0;
    a_loc = core_local;
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ********
  // Tests
  // ********
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    chk("c_oe", ctrl_port_third_oe, 8'h00);
    rd(8'h10, 8'h00, RESP_OKAY);
    rd(8'h2c, 8'h00, RESP_OKAY);
    rd(8'h60, 8'h00, RESP_SLVERR);
    rd(8'h54, 8'h02, RESP_OKAY);
    $display("test reset done");
    wr(8'h00, 8'ha5, RESP_OKAY);
    wr(8'h04, 8'h3c, RESP_OKAY);
    chk("a_oe", gp_port_first_oe, 8'ha5);
    chk("a_out", gp_port_first_out, 8'h3c);
    rd(8'h08, 8'h5a, RESP_OKAY);
    wr(8'h30, 8'h01, RESP_OKAY);
    chk("d_oe", mux_port_fourth_oe, 8'hff);
    wr(8'h30, 8'h00, RESP_OKAY);
    chk("d_oe", mux_port_fourth_oe, 8'h00);
    $display("test ports done");
    {nmi_n_in, rising_irq_in, upper_analog_edge_inputs} <= 6'h10;
    repeat (6) @(posedge sys_clk);
    rd(8'h58, 8'h7b, RESP_OKAY);
    serial_clk_out <= 1'b1;
    wr(8'h2c, 8'h1d, RESP_OKAY);
    chk("sck_oe", ctrl_port_third_oe[2], 1'b0);
    wr(8'h50, 8'h08, RESP_OKAY);
    chk("sck_oe", ctrl_port_third_oe[2], 1'b1);
    chk("c_alt", {ctrl_port_third_out[4], ctrl_port_third_out[2:0]}, 4'h5);
    ctrl_port_third_in <= 8'hf7;
    repeat (6) begin
      @(posedge sys_clk);
      hit |= irq2_req;
    end
    chk("irq2", hit, 1'b1);
    chk("ti", timer_input_line, 1'b0);
    $display("test edges done");
    for (int i = 1; i < 5; i++) begin
      wr(8'h50, 8'(i), RESP_OKAY);
      cyc(16'hfe34, 1'b1, 1'b1, 8'h77);
      chk("ad_lo", a_d, 8'h34);
      chk("f_oe", a_foe, fmask[i]);
      chk("f_hi", a_f & fmask[i], 8'hfe & fmask[i]);
      chk("flags", {a_m1, a_io}, 2'h1);
    end
    cyc(16'hfe34, 1'b0, 1'b0, 8'h00);
    @(posedge sys_clk);
    chk("rdata", core_rdata, 8'h77);
    chk("flags", {a_m1, a_io}, 2'h2);
    for (int i = 0; i < 4; i++) begin
      cyc(lad[i], 1'b0, 1'b0, 8'h00);
      chk("local", a_loc, i == 0 || i == 3);
    end
    wr(8'h50, 8'h00, RESP_OKAY);
    cyc(16'h2000, 1'b0, 1'b0, 8'h00);
    chk("local", a_loc, 1'b1);
    $display("test expansion done");
    close_out();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    close_out();
  end
endmodule // io_ports_and_memory_expansion_tb

bind iopx_ports iopx_chk chk_u (.*);
